// file: rtl/scdf_buf2.v
`timescale 1ns/1ps
// ****************************************
// Two-entry word buffer, registered read data
// ****************************************
module scdf_buf2 (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Fill side
  input  wire        in_valid_i,
  output wire        in_ready_o,
  input  wire [31:0] in_data_i,
  // Drain side
  output reg         out_valid_o,
  input  wire        out_ready_i,
  output reg  [31:0] out_data_o
);
  reg [31:0] spare_reg;   // Second entry
  reg        spare_v_reg; // Second entry valid
  // Ready only while the spare slot is free, so a stall never drops a word
  assign in_ready_o = ~spare_v_reg;
  // Skid register pair
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      spare_v_reg <= 1'b0;
      out_data_o  <= 32'h00000000;
      spare_reg   <= 32'h00000000;
    end else begin
      if (!out_valid_o || out_ready_i) begin
        // Head is free or leaving
        if (spare_v_reg) begin
          out_data_o  <= spare_reg;
          out_valid_o <= 1'b1;
          spare_v_reg <= 1'b0;
        end else begin
          out_data_o  <= in_data_i;
          out_valid_o <= in_valid_i;
        end
      end else if (in_valid_i && !spare_v_reg) begin
        // Head stalled, park in spare
        spare_reg   <= in_data_i;
        spare_v_reg <= 1'b1;
      end
    end
  end
endmodule // scdf_buf2

// file: rtl/scdf_consts.vh
`ifndef SCDF_CONSTS_VH
`define SCDF_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SCDF_OFS_CHAN_CTRL   9'h134
`define SCDF_OFS_TX_WORD     9'h138
`define SCDF_OFS_RX_WORD     9'h13C
`define SCDF_OFS_XFER_LEVEL  9'h17C
// ****************************************
// Field positions
// ****************************************
`define SCDF_CTRL_EN_BIT     0
`define SCDF_CTRL_EXT_HI     15
`define SCDF_CTRL_EXT_LO     8
`define SCDF_LVL_WORD_COUNT_LIMIT_HI     31
`define SCDF_LVL_WORD_COUNT_LIMIT_LO     16
`define SCDF_LVL_AFL_HI      15
`define SCDF_LVL_AFL_LO      8
`define SCDF_LVL_AEL_HI      7
`define SCDF_LVL_AEL_LO      0
// ****************************************
// Reset values and figures
// ****************************************
`define SCDF_RST_WORD        32'h00000000
`define SCDF_EXT_STEP_SHIFT  4
`define SCDF_FIFO_BYTES      6'h10
`define SCDF_ADDR_W          9
`endif

// file: rtl/scdf_top.v
`timescale 1ns/1ps
`include "scdf_consts.vh"
// How it works
// - Extension joins divider only with fine granularity
// - Ratio is divider plus one plus 16*extension
// - Channel active only while enable bit set
// - Transmit register holds one 32-bit word
// - Byte words sit at lane 0 or 3
// - Receive register holds last received word
// - Count field reads index once transfer starts
// - Read request when fill exceeds almost-full level
// - Write request when room exceeds almost-empty level
// - End flag cleared on load, set on finish
module scdf_top (
  // Clock and reset
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  // Register port
  input  wire [8:0]  ADDR_I,
  input  wire [31:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [31:0] RDATA_O,
  // Configuration from channel setup
  input  wire [3:0]  BASE_CLOCK_DIVIDER_I,
  input  wire        CLOCK_GRANULARITY_SELECT_I,
  input  wire [4:0]  WORD_LEN_M1_I,
  input  wire        BIG_ENDIAN_I,
  // Shift engine
  input  wire        SHIFT_LOAD_I,
  input  wire        WORD_DONE_I,
  input  wire [31:0] RX_SHIFT_DATA_I,
  input  wire [5:0]  RX_FILL_BYTES_I,
  input  wire [5:0]  TX_FILL_BYTES_I,
  input  wire        TX_READY_I,
  // Status and control out
  output reg         CHAN_ACTIVE_O,
  output reg  [11:0] DIV_RATIO_M1_O,
  output reg         TX_VALID_O,
  output reg  [31:0] TX_DATA_O,
  output reg         END_OF_TRANSFER_FLAG_O,
  output reg         RX_REQ_O,
  output reg         TX_REQ_O,
  output reg         XFER_DONE_O
);
  // ****************************************
  // Usage notes
  // ****************************************
  // Register strobes are single cycles and may run back to back
  // Read data stand for one cycle only, zero otherwise
  // Unmapped addresses read as zero and ignore writes
  // A transmit write while a push is still pending is dropped;
  //   software should pace writes by the write request
  // Word length and byte order are used live, not latched:
  //   change them only while no word is in flight
  // Stored words are masked again on read, so a later length
  //   change never exposes stale upper bits
  // The word count opens on the first shift load after a nonzero
  //   count is written with the channel enabled
  // While counting, the count field reads back the word index
  // Clearing the enable aborts the count and drops an offered word;
  //   words still in the buffer wait for the channel to return
  // Fill levels come from the shift engine and are not clipped:
  //   a level above sixteen wraps the room figure
  // Two buffer slots plus the output stage hold three words,
  //   so a stalled shift engine never loses one
  // ****************************************
  // Register storage
  // ****************************************
  reg        chan_en_reg;              // Channel enable
  reg [7:0]  clock_ratio_extension_reg;// Divider extension
  reg [15:0] word_count_limit_reg;     // Programmed word count
  reg [7:0]  almost_full_level_reg;    // Receive threshold minus one
  reg [7:0]  almost_empty_level_reg;   // Transmit threshold minus one
  reg [31:0] tx_word_reg;              // Transmit word, moved to lane 0 and masked
  reg [31:0] rx_word_reg;              // Last received word
  reg [15:0] word_index_reg;           // Current transfer index
  reg        xfer_started_reg;         // Counted transfer in progress
  reg        tx_push_reg;              // Pending push into buffer
  wire       buf_in_ready;             // Buffer can take a word
  wire       buf_out_valid;            // Buffer head valid
  wire [31:0] buf_out_data;            // Buffer head word
  wire       buf_out_ready;            // Buffer head may move on
  // ****************************************
  // Byte-lane placement helpers
  // ****************************************
  // Byte words from a big-endian host land in lane 3; move to lane 0
  function [31:0] lane_in;
    input [31:0] d;
    input        be;
    input [4:0]  len;
    begin
      // Only byte words move; wider words pass as written
      if (be && len == 5'h07)
        lane_in = {24'h000000, d[31:24]};
      else
        lane_in = d;
    end
  endfunction
  // Outbound byte word moved to lane 3 for big-endian readers
  function [31:0] lane_out;
    input [31:0] d;
    input        be;
    input [4:0]  len;
    begin
      // Only byte words move; wider words pass as stored
      if (be && len == 5'h07)
        lane_out = {d[7:0], 24'h000000};
      else
        lane_out = d;
    end
  endfunction
  // Keep only the configured word length
  function [31:0] len_mask;
    input [4:0] len;
    begin
      len_mask = 32'hFFFFFFFF >> (5'h1F - len);
    end
  endfunction
  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge CORE_CLK_I) begin
    // Reset: all fields back to zero
    if (!RST_N_I) begin
      chan_en_reg               <= 1'b0;
      clock_ratio_extension_reg <= 8'h00;
      word_count_limit_reg      <= 16'h0000;
      almost_full_level_reg     <= 8'h00;
      almost_empty_level_reg    <= 8'h00;
      tx_word_reg               <= `SCDF_RST_WORD;
      tx_push_reg               <= 1'b0;
    end else begin
      // Push lasts until the buffer takes it
      if (tx_push_reg && buf_in_ready)
        tx_push_reg <= 1'b0;
      // Decode the written address
      if (WR_I) begin
        case (ADDR_I)
          `SCDF_OFS_CHAN_CTRL: begin
            // Enable and divider extension
            chan_en_reg               <= WDATA_I[`SCDF_CTRL_EN_BIT];
            clock_ratio_extension_reg <= WDATA_I[`SCDF_CTRL_EXT_HI:`SCDF_CTRL_EXT_LO];
          end
          `SCDF_OFS_TX_WORD: begin
            // Transmit word, moved to lane 0 and masked to length
            // A write while a push is still pending is dropped, not overwritten
            if (!tx_push_reg) begin
              tx_word_reg <= lane_in(WDATA_I, BIG_ENDIAN_I, WORD_LEN_M1_I)
                             & len_mask(WORD_LEN_M1_I);
              tx_push_reg <= 1'b1;
            end
          end
          `SCDF_OFS_XFER_LEVEL: begin
            // Count and both thresholds
            word_count_limit_reg   <= WDATA_I[`SCDF_LVL_WORD_COUNT_LIMIT_HI:`SCDF_LVL_WORD_COUNT_LIMIT_LO];
            almost_full_level_reg  <= WDATA_I[`SCDF_LVL_AFL_HI:`SCDF_LVL_AFL_LO];
            almost_empty_level_reg <= WDATA_I[`SCDF_LVL_AEL_HI:`SCDF_LVL_AEL_LO];
          end
          default: begin
            // Unmapped writes are ignored
          end
        endcase
      end
    end
  end
  // ****************************************
  // Transmit buffer toward the shift engine
  // ****************************************
  // Head moves on only into a free or draining output stage
  assign buf_out_ready = chan_en_reg & (~TX_VALID_O | TX_READY_I);
  // Two slots absorb a stall without losing a word
  scdf_buf2 u_buf (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (tx_push_reg),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (tx_word_reg),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );
  // ****************************************
  // Receive word, counter and end flag
  // ****************************************
  always @(posedge CORE_CLK_I) begin
    // Reset: empty word, counter idle, flag low
    if (!RST_N_I) begin
      rx_word_reg            <= `SCDF_RST_WORD;
      word_index_reg         <= 16'h0000;
      xfer_started_reg       <= 1'b0;
      END_OF_TRANSFER_FLAG_O <= 1'b0;
      XFER_DONE_O            <= 1'b0;
    end else begin
      // Done pulse lasts one cycle
      XFER_DONE_O <= 1'b0;
      // Finish beats load in the same cycle: the set wins
      if (WORD_DONE_I)
        END_OF_TRANSFER_FLAG_O <= 1'b1;
      else if (SHIFT_LOAD_I)
        END_OF_TRANSFER_FLAG_O <= 1'b0;
      // Capture the finished word at its own length
      if (WORD_DONE_I)
        rx_word_reg <= RX_SHIFT_DATA_I & len_mask(WORD_LEN_M1_I);
      // Counting only with a nonzero limit and an active channel
      if (chan_en_reg && word_count_limit_reg != 16'h0000) begin
        // First load opens the count
        if (SHIFT_LOAD_I && !xfer_started_reg) begin
          xfer_started_reg <= 1'b1;
          word_index_reg   <= 16'h0000;
        end
        // Each finished word moves the index
        if (WORD_DONE_I && (xfer_started_reg || SHIFT_LOAD_I)) begin
          if (word_index_reg + 16'h0001 == word_count_limit_reg) begin
            // Last word: close the count and pulse
            xfer_started_reg <= 1'b0;
            XFER_DONE_O      <= 1'b1;
            word_index_reg   <= 16'h0000;
          end else begin
            word_index_reg <= word_index_reg + 16'h0001;
          end
        end
      end else begin
        // Counter off or channel idle: hold at zero
        xfer_started_reg <= 1'b0;
        word_index_reg   <= 16'h0000;
      end
    end
  end
  // ****************************************
  // Divider, requests and outputs
  // ****************************************
  // All outputs registered so the shift engine sees clean levels
  always @(posedge CORE_CLK_I) begin
    // Reset: nothing offered, nothing requested
    if (!RST_N_I) begin
      CHAN_ACTIVE_O  <= 1'b0;
      DIV_RATIO_M1_O <= 12'h000;
      TX_VALID_O     <= 1'b0;
      TX_DATA_O      <= 32'h00000000;
      RX_REQ_O       <= 1'b0;
      TX_REQ_O       <= 1'b0;
    end else begin
      // Enable seen one cycle late
      CHAN_ACTIVE_O <= chan_en_reg;
      // Extension only counts at one-cycle granularity
      if (CLOCK_GRANULARITY_SELECT_I)
        DIV_RATIO_M1_O <= {clock_ratio_extension_reg, BASE_CLOCK_DIVIDER_I};
      else
        DIV_RATIO_M1_O <= {8'h00, BASE_CLOCK_DIVIDER_I};
      // Output stage is a third slot: it reloads only when empty or taken,
      // so a stall by the shift engine keeps the offered word in place
      if (!chan_en_reg) begin
        // Inactive channel offers nothing
        TX_VALID_O <= 1'b0;
      end else if (!TX_VALID_O || TX_READY_I) begin
        // Empty or taken: pull the next head
        TX_VALID_O <= buf_out_valid;
        TX_DATA_O  <= buf_out_data;
      end
      // Requests only while the channel is on
      // Threshold compares on level plus one, widened to avoid wrap
      RX_REQ_O <= chan_en_reg &&
                  ({3'b000, RX_FILL_BYTES_I} >= {1'b0, almost_full_level_reg} + 9'h001);
      TX_REQ_O <= chan_en_reg &&
                  ({3'b000, `SCDF_FIFO_BYTES - TX_FILL_BYTES_I}
                   >= {1'b0, almost_empty_level_reg} + 9'h001);
    end
  end
  // ****************************************
  // Register reads, data one cycle later
  // ****************************************
  always @(posedge CORE_CLK_I) begin
    // Reset: bus reads zero
    if (!RST_N_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RD_I) begin
      case (ADDR_I)
        // Reserved bits read as zero
        `SCDF_OFS_CHAN_CTRL:
          RDATA_O <= {16'h0000, clock_ratio_extension_reg, 7'h00, chan_en_reg};
        // Re-mask in case the word length changed since the write
        `SCDF_OFS_TX_WORD:
          RDATA_O <= lane_out(tx_word_reg & len_mask(WORD_LEN_M1_I),
                              BIG_ENDIAN_I, WORD_LEN_M1_I);
        `SCDF_OFS_RX_WORD:
          RDATA_O <= lane_out(rx_word_reg & len_mask(WORD_LEN_M1_I),
                              BIG_ENDIAN_I, WORD_LEN_M1_I);
        // Index replaces the count while running
        `SCDF_OFS_XFER_LEVEL:
          RDATA_O <= {(xfer_started_reg ? word_index_reg : word_count_limit_reg),
                      almost_full_level_reg, almost_empty_level_reg};
        // Holes read as zero
        default:
          RDATA_O <= 32'h00000000;
      endcase
    end else begin
      // Bus idle: drive zero
      RDATA_O <= 32'h00000000;
    end
  end
endmodule // scdf_top

// file: test/scdf_peer.sv
`timescale 1ns/1ps
// ********************************
// Serial peer: takes words, echoes them back after LAT cycles
// ********************************
module scdf_peer #(parameter int LAT = 20) (
  input  wire        clk_i,
  input  wire        stall_i,
  input  wire        tx_valid_i,
  input  wire [31:0] tx_data_i,
  output logic        tx_ready_o,
  output logic        shift_load_o,
  output logic        word_done_o,
  output logic [31:0] rx_data_o
);
  logic [31:0] got[$]; // Words taken, in order
  logic [31:0] word = 32'h0; // Word in flight
  int cnt = 0; // Cycles left in the word
  int n_done = 0; // Words finished
  initial begin
    tx_ready_o = 1'b0;
    shift_load_o = 1'b0;
    word_done_o = 1'b0;
    rx_data_o = 32'h0;
  end
  // One word at a time; ready only when idle and not stalled
  always @(posedge clk_i) begin
    shift_load_o <= 1'b0;
    word_done_o <= 1'b0;
    rx_data_o <= (cnt == 1) ? word : ~word; // Data means nothing off the done pulse
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        word_done_o <= 1'b1;
        n_done <= n_done + 1;
      end
    end else if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
      word <= tx_data_i;
      shift_load_o <= 1'b1;
      cnt <= LAT;
    end
    tx_ready_o <= !stall_i && cnt <= 1 && !(tx_valid_i && tx_ready_o);
  end
endmodule // scdf_peer

// file: test/scdf_top_monitor.sv
`timescale 1ns/1ps
`include "scdf_consts.vh"
// ********************************
// Port checker
// ********************************
module scdf_top_monitor (
  input wire        CORE_CLK_I,
  input wire        RST_N_I,
  input wire [8:0]  ADDR_I,
  input wire        RD_I,
  input wire [31:0] RDATA_O,
  input wire [3:0]  BASE_CLOCK_DIVIDER_I,
  input wire        CLOCK_GRANULARITY_SELECT_I,
  input wire [4:0]  WORD_LEN_M1_I,
  input wire        BIG_ENDIAN_I,
  input wire        SHIFT_LOAD_I,
  input wire        WORD_DONE_I,
  input wire [5:0]  RX_FILL_BYTES_I,
  input wire [5:0]  TX_FILL_BYTES_I,
  input wire        CHAN_ACTIVE_O,
  input wire [11:0] DIV_RATIO_M1_O,
  input wire        TX_VALID_O,
  input wire        END_OF_TRANSFER_FLAG_O,
  input wire        RX_REQ_O,
  input wire        TX_REQ_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Divider held two edges, so the registered ratio has caught up
  sequence div_steady;
    $stable(BASE_CLOCK_DIVIDER_I) ##1 $stable(BASE_CLOCK_DIVIDER_I);
  endsequence
  a_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside answer");
  a_hole_zero: assert property (RD_I && !(ADDR_I inside {`SCDF_OFS_CHAN_CTRL,
    `SCDF_OFS_TX_WORD, `SCDF_OFS_RX_WORD, `SCDF_OFS_XFER_LEVEL}) |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_lane_low: assert property (RD_I && ADDR_I == `SCDF_OFS_TX_WORD && !BIG_ENDIAN_I
    && WORD_LEN_M1_I == 5'h07 |=> RDATA_O[31:8] == 24'h0) else $error("byte lane wrong");
  a_div_base: assert property (div_steady |-> DIV_RATIO_M1_O[3:0] == BASE_CLOCK_DIVIDER_I)
    else $error("divider bits wrong");
  a_ext_coarse: assert property (!CLOCK_GRANULARITY_SELECT_I |=> DIV_RATIO_M1_O[11:4] == 8'h0)
    else $error("extension used in coarse mode");
  a_tx_gated: assert property (TX_VALID_O |-> CHAN_ACTIVE_O)
    else $error("word offered while inactive");
  a_rx_empty: assert property (RX_FILL_BYTES_I == 6'h00 |=> !RX_REQ_O)
    else $error("read request on empty buffer");
  a_tx_full: assert property (TX_FILL_BYTES_I == `SCDF_FIFO_BYTES |=> !TX_REQ_O)
    else $error("write request with no room");
  a_eot_clear: assert property (SHIFT_LOAD_I && !WORD_DONE_I |=> !END_OF_TRANSFER_FLAG_O)
    else $error("end flag not cleared");
  a_eot_set: assert property (WORD_DONE_I |=> END_OF_TRANSFER_FLAG_O)
    else $error("end flag not set");
endmodule // scdf_top_monitor
bind scdf_top scdf_top_monitor mon (.CORE_CLK_I, .RST_N_I, .ADDR_I, .RD_I, .RDATA_O,
  .BASE_CLOCK_DIVIDER_I, .CLOCK_GRANULARITY_SELECT_I, .WORD_LEN_M1_I, .BIG_ENDIAN_I,
  .SHIFT_LOAD_I, .WORD_DONE_I, .RX_FILL_BYTES_I, .TX_FILL_BYTES_I, .CHAN_ACTIVE_O,
  .DIV_RATIO_M1_O, .TX_VALID_O, .END_OF_TRANSFER_FLAG_O, .RX_REQ_O, .TX_REQ_O);

// file: test/scdf_top_tb.sv
`timescale 1ns/1ps
`include "scdf_consts.vh"
module scdf_top_tb;
  logic CORE_CLK_I, RST_N_I, WR_I, RD_I, CLOCK_GRANULARITY_SELECT_I, BIG_ENDIAN_I, stall;
  logic [8:0] ADDR_I;
  logic [31:0] WDATA_I, RDATA_O, RX_SHIFT_DATA_I, TX_DATA_O;
  logic [3:0] BASE_CLOCK_DIVIDER_I;
  logic [4:0] WORD_LEN_M1_I;
  logic [5:0] RX_FILL_BYTES_I, TX_FILL_BYTES_I;
  logic [11:0] DIV_RATIO_M1_O;
  logic SHIFT_LOAD_I, WORD_DONE_I, TX_READY_I, CHAN_ACTIVE_O, TX_VALID_O;
  logic END_OF_TRANSFER_FLAG_O, RX_REQ_O, TX_REQ_O, XFER_DONE_O;
  int n_mismatch = 0;
  int total_checks = 0;
  int i;
  scdf_top dut (.CORE_CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .BASE_CLOCK_DIVIDER_I, .CLOCK_GRANULARITY_SELECT_I, .WORD_LEN_M1_I, .BIG_ENDIAN_I,
    .SHIFT_LOAD_I, .WORD_DONE_I, .RX_SHIFT_DATA_I, .RX_FILL_BYTES_I, .TX_FILL_BYTES_I,
    .TX_READY_I, .CHAN_ACTIVE_O, .DIV_RATIO_M1_O, .TX_VALID_O, .TX_DATA_O,
    .END_OF_TRANSFER_FLAG_O, .RX_REQ_O, .TX_REQ_O, .XFER_DONE_O);
  scdf_peer peer (.clk_i(CORE_CLK_I), .stall_i(stall), .tx_valid_i(TX_VALID_O),
    .tx_data_i(TX_DATA_O), .tx_ready_o(TX_READY_I), .shift_load_o(SHIFT_LOAD_I),
    .word_done_o(WORD_DONE_I), .rx_data_o(RX_SHIFT_DATA_I));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    WDATA_I <= v;
    WR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
    #1 chk(RDATA_O, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge CORE_CLK_I);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    CORE_CLK_I = 1'b0;
    forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    RST_N_I = 1'b0;
    {WR_I, RD_I, ADDR_I, WDATA_I, BIG_ENDIAN_I, RX_FILL_BYTES_I, TX_FILL_BYTES_I} = '0;
    {stall, CLOCK_GRANULARITY_SELECT_I, BASE_CLOCK_DIVIDER_I} = 6'h3F;
    WORD_LEN_M1_I = 5'h1F;
    repeat (16) @(posedge CORE_CLK_I);
    RST_N_I <= 1'b1;
    rd(`SCDF_OFS_CHAN_CTRL, 32'h0);
    rd(`SCDF_OFS_TX_WORD, 32'h0);
    rd(`SCDF_OFS_RX_WORD, 32'h0);
    rd(`SCDF_OFS_XFER_LEVEL, 32'h0);
    rd(9'h140, 32'h0);
    wr(`SCDF_OFS_CHAN_CTRL, 32'hFFFFFF01);
    rd(`SCDF_OFS_CHAN_CTRL, 32'h0000FF01);
    settle();
    chk({20'h0, DIV_RATIO_M1_O}, 32'hFFF);
    chk({31'h0, CHAN_ACTIVE_O}, 32'h1);
    wr(`SCDF_OFS_CHAN_CTRL, 32'h00000100);
    settle();
    chk({20'h0, DIV_RATIO_M1_O}, 32'h01F);
    chk({31'h0, CHAN_ACTIVE_O}, 32'h0);
    CLOCK_GRANULARITY_SELECT_I <= 1'b0;
    settle();
    chk({20'h0, DIV_RATIO_M1_O}, 32'h00F);
    // Two counted words queued while the peer stalls
    wr(`SCDF_OFS_XFER_LEVEL, 32'h00020F03);
    rd(`SCDF_OFS_XFER_LEVEL, 32'h00020F03);
    wr(`SCDF_OFS_CHAN_CTRL, 32'h1);
    wr(`SCDF_OFS_TX_WORD, 32'hA5A51234);
    wr(`SCDF_OFS_TX_WORD, 32'h0F1E2D3C);
    rd(`SCDF_OFS_TX_WORD, 32'h0F1E2D3C);
    settle();
    stall <= 1'b0;
    for (i = 0; peer.n_done < 1 && i < 200; i++) @(posedge CORE_CLK_I);
    rd(`SCDF_OFS_XFER_LEVEL, 32'h00010F03);
    for (i = 0; XFER_DONE_O !== 1'b1 && i < 200; i++) @(posedge CORE_CLK_I);
    chk({31'h0, XFER_DONE_O}, 32'h1);
    settle();
    chk({31'h0, END_OF_TRANSFER_FLAG_O}, 32'h1);
    rd(`SCDF_OFS_XFER_LEVEL, 32'h00020F03);
    chk(peer.got[0], 32'hA5A51234);
    chk(peer.got[1], 32'h0F1E2D3C);
    rd(`SCDF_OFS_RX_WORD, 32'h0F1E2D3C);
    // Fill levels around the thresholds: full 16 of 16, room 4 of 4
    for (i = 0; i < 3; i++) begin
      RX_FILL_BYTES_I <= (i == 0) ? 6'h0F : (i == 1) ? 6'h10 : 6'h00;
      TX_FILL_BYTES_I <= (i == 0) ? 6'h0D : (i == 1) ? 6'h0C : 6'h10;
      settle();
      chk({30'h0, RX_REQ_O, TX_REQ_O}, (i == 1) ? 32'h3 : 32'h0);
    end
    // Byte words in both lanes, echoed back by the peer
    WORD_LEN_M1_I <= 5'h07;
    wr(`SCDF_OFS_TX_WORD, 32'h12345678);
    rd(`SCDF_OFS_TX_WORD, 32'h00000078);
    BIG_ENDIAN_I <= 1'b1;
    wr(`SCDF_OFS_TX_WORD, 32'hAB000000);
    rd(`SCDF_OFS_TX_WORD, 32'hAB000000);
    for (i = 0; peer.n_done < 4 && i < 200; i++) @(posedge CORE_CLK_I);
    settle();
    rd(`SCDF_OFS_RX_WORD, 32'hAB000000);
    end_sim();
  end
endmodule // scdf_top_tb
